// ===== rtl/tmds_port_params.svh
`ifndef TMDS_PORT_PARAMS_SVH
`define TMDS_PORT_PARAMS_SVH

// Register reset value
`define DPC_RESET 32'h0000_0018

// Field positions of digital_port_control
`define DPC_EN_BIT 31
`define DPC_PIPE_HI 30
`define DPC_PIPE_LO 29
`define DPC_DEPTH_HI 28
`define DPC_DEPTH_LO 26
`define DPC_REV_BIT 15
`define DPC_ENC_HI 11
`define DPC_ENC_LO 10
`define DPC_HDMI_BIT 9
`define DPC_AUD_BIT 6
`define DPC_POL_HI 4
`define DPC_POL_LO 3
`define DPC_DET_BIT 2

// Field codes
`define ENC_TMDS 2'h2
`define DEPTH_12BPC 3'h3

// Cycles waited after reset release before the presence strap is taken
`define DET_WAIT 2'h3

`endif

// ===== rtl/tmds_port_pkg.sv
package tmds_port_pkg;

  // Port configuration fields
  typedef struct packed {
    logic en;
    logic [1:0] pipe;
    logic [2:0] depth;
    logic rev;
    logic [1:0] enc;
    logic hdmi;
    logic aud;
    logic [1:0] pol;
  } cfg_t;

  // State in the register clock domain
  typedef struct packed {
    cfg_t wr;
    cfg_t xfer;
    logic dirty;
    logic req;
    logic ack_s1;
    logic ack_s2;
    logic hpd_s1;
    logic hpd_s2;
    logic dsb_s1;
    logic dsb_s2;
    logic [1:0] det_cnt;
    logic det_done;
    logic det;
    logic hot;
    logic aud_pres;
    logic [31:0] rdata;
  } main_st_t;

  // State in the link clock domain
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic ack;
    cfg_t pend;
    cfg_t act;
    logic vb;
    logic oe;
    logic [1:0] ctl;
    logic island;
    logic take;
    logic [31:0] data;
  } link_st_t;

endpackage

// ===== rtl/tmds_port_control.sv
`timescale 1ns/1ps
`include "tmds_port_params.svh"

// Behaviour
// [RL1] Enable takes effect at next vertical blank; disabled port rests at lowest power.
// [RL2] With enable clear the port interface is off and outputs high impedance.
// [RL3] Audio goes out only when port enable and audio enable are both set.
// [RL4] Pipe select 00 A, 01 B, 10 C, 11 reserved; applies at next blank.
// [RL5] Depth 000 is 8 bpc, 011 is 12 bpc; applies at next blank.
// [RL6] Software changes colour depth only during a full mode set.
// [RL7] Lane reversal bit reverses the order of the four data lanes.
// [RL8] Lane reversal is locked while enabled; updates on disable then re-enable.
// [RL9] Encoding code 10 selects TMDS; all other codes are reserved.
// [RL10] In TMDS mode hot plug indications come from the hot plug pin.
// [RL11] Software programs encoding during display detection before using the port.
// [RL12] Interface type set sends null packets of zero bytes for HDMI.
// [RL13] Interface type clear gives plain DVI without packets or audio.
// [RL14] With audio enabled and samples available, audio merges into the stream.
// [RL15] Audio enable bit tells the audio driver an HDMI output is present.
// [RL16] Sync polarity 00 both low, 01 VS low, 10 HS low, 11 both high.
// [RL17] Inverted sync sent as sync-blank-sync, normal sync as blank-sync-blank.
// [RL18] Presence bit shows boot level of serial bus data line, always valid; the code reads it as 0 after reset until the strap is taken.
// [RL19] Software never enables this port with the same-letter DisplayPort port.
// [RL20] Reads return written values while hardware uses old ones until update.
module tmds_port_control (
  // Register clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  // Pins
  input wire logic hot_plug_detect_pin_i,
  input wire logic display_serial_bus_data_i,
  // Status to system
  output logic hot_plug_o,
  output logic audio_present_o,
  // Link clock and timing
  input wire logic link_clk_i,
  input wire logic vblank_i,
  input wire logic de_i,
  input wire logic hs_i,
  input wire logic vs_i,
  input wire logic [35:0] pix_i,
  // Audio samples
  input wire logic audio_valid_i,
  input wire logic [31:0] audio_data_i,
  output logic audio_take_o,
  // Link outputs
  output logic [1:0] pipe_sel_o,
  output logic [31:0] lane_data_o,
  output logic [1:0] lane_ctl_o,
  output logic lane_island_o,
  output logic lane_oe_o
);

  // ==========================================================
  // Helpers
  function automatic tmds_port_pkg::cfg_t to_cfg(input logic [31:0] w);
    tmds_port_pkg::cfg_t c;
    c.en = w[`DPC_EN_BIT];
    c.pipe = w[`DPC_PIPE_HI:`DPC_PIPE_LO];
    c.depth = w[`DPC_DEPTH_HI:`DPC_DEPTH_LO];
    c.rev = w[`DPC_REV_BIT];
    c.enc = w[`DPC_ENC_HI:`DPC_ENC_LO];
    c.hdmi = w[`DPC_HDMI_BIT];
    c.aud = w[`DPC_AUD_BIT];
    c.pol = w[`DPC_POL_HI:`DPC_POL_LO];
    return c;
  endfunction

  function automatic logic [31:0] to_word(input tmds_port_pkg::cfg_t c,
                                          input logic det);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`DPC_EN_BIT] = c.en;
    w[`DPC_PIPE_HI:`DPC_PIPE_LO] = c.pipe;
    w[`DPC_DEPTH_HI:`DPC_DEPTH_LO] = c.depth;
    w[`DPC_REV_BIT] = c.rev;
    w[`DPC_ENC_HI:`DPC_ENC_LO] = c.enc;
    w[`DPC_HDMI_BIT] = c.hdmi;
    w[`DPC_AUD_BIT] = c.aud;
    w[`DPC_POL_HI:`DPC_POL_LO] = c.pol;
    w[`DPC_DET_BIT] = det;
    return w;
  endfunction

  function automatic logic [31:0] rev_lanes(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  // ==========================================================
  // Register domain
  tmds_port_pkg::main_st_t ms_r;
  tmds_port_pkg::main_st_t ms_nxt;
  tmds_port_pkg::link_st_t ls_r;
  tmds_port_pkg::link_st_t ls_nxt;

  always_comb begin
    ms_nxt = ms_r;
    // Pin and handshake synchronisers
    ms_nxt.hpd_s1 = hot_plug_detect_pin_i;
    ms_nxt.hpd_s2 = ms_r.hpd_s1;
    ms_nxt.dsb_s1 = display_serial_bus_data_i;
    ms_nxt.dsb_s2 = ms_r.dsb_s1;
    ms_nxt.ack_s1 = ls_r.ack;
    ms_nxt.ack_s2 = ms_r.ack_s1;
    // First stage takes the write and is what reads return
    if (reg_wr_i) begin
      ms_nxt.wr = to_cfg(reg_wdata_i); // [RL20]
      ms_nxt.dirty = 1'b1;
    end
    // Hand a stable copy to the link side when it has taken the last one
    if (ms_r.dirty && (ms_r.req == ms_r.ack_s2) && !reg_wr_i) begin
      ms_nxt.xfer = ms_r.wr;
      ms_nxt.req = ~ms_r.req;
      ms_nxt.dirty = 1'b0;
    end
    // Presence strap taken once after reset, kept regardless of enable
    if (!ms_r.det_done) begin
      if (ms_r.det_cnt == `DET_WAIT) begin
        ms_nxt.det = ms_r.dsb_s2; // [RL18]
        ms_nxt.det_done = 1'b1;
      end else begin
        ms_nxt.det_cnt = ms_r.det_cnt + 2'h1;
      end
    end
    ms_nxt.hot = ms_r.hpd_s2 & (ms_r.wr.enc == `ENC_TMDS); // [RL10]
    ms_nxt.aud_pres = ms_r.wr.aud; // [RL15]
    ms_nxt.rdata = to_word(ms_r.wr, ms_r.det); // [RL20]
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ms_r <= '0;
      ms_r.wr <= to_cfg(`DPC_RESET);
      ms_r.xfer <= to_cfg(`DPC_RESET);
      ms_r.rdata <= `DPC_RESET;
    end else begin
      ms_r <= ms_nxt;
    end
  end

  assign reg_rdata_o = ms_r.rdata;
  assign hot_plug_o = ms_r.hot;
  assign audio_present_o = ms_r.aud_pres;

  // ==========================================================
  // Link reset synchroniser
  logic lrst_s1_r;
  logic lrst_s2_r;

  always_ff @(posedge link_clk_i) begin
    lrst_s1_r <= rstn_i;
    lrst_s2_r <= lrst_s1_r;
  end

  // ==========================================================
  // Link domain
  logic tmds_on;
  logic aud_go;
  logic [31:0] pix_lanes;

  always_comb begin
    ls_nxt = ls_r;
    ls_nxt.req_s1 = ms_r.req;
    ls_nxt.req_s2 = ls_r.req_s1;
    // Take the handed copy; it stays still until the ack returns
    if (ls_r.req_s2 != ls_r.ack) begin
      ls_nxt.pend = ms_r.xfer;
      ls_nxt.ack = ls_r.req_s2;
    end
    // Second stage loads on the rising edge of vertical blank
    ls_nxt.vb = vblank_i;
    if (vblank_i && !ls_r.vb) begin
      ls_nxt.act.en = ls_r.pend.en; // [RL1]
      ls_nxt.act.pipe = ls_r.pend.pipe; // [RL4]
      ls_nxt.act.depth = ls_r.pend.depth; // [RL5]
      ls_nxt.act.enc = ls_r.pend.enc;
      ls_nxt.act.hdmi = ls_r.pend.hdmi;
      ls_nxt.act.aud = ls_r.pend.aud;
      ls_nxt.act.pol = ls_r.pend.pol;
      if (ls_r.pend.en && !ls_r.act.en) begin
        ls_nxt.act.rev = ls_r.pend.rev; // [RL8]
      end
    end
    tmds_on = ls_r.act.en && (ls_r.act.enc == `ENC_TMDS); // [RL9]
    aud_go = tmds_on && ls_r.act.hdmi && ls_r.act.aud && audio_valid_i && !de_i; // [RL3]
    // 8 bpc uses three lanes; 12 bpc carries the low nibbles of lanes 0 and 1 on lane 3
    pix_lanes = {8'h00, pix_i[35:28], pix_i[23:16], pix_i[11:4]};
    if (ls_r.act.depth == `DEPTH_12BPC) begin
      pix_lanes[31:24] = {pix_i[3:0], pix_i[15:12]}; // [RL5]
    end
    ls_nxt.take = aud_go;
    if (!tmds_on) begin
      // Idle: outputs released, lanes quiet
      ls_nxt.oe = 1'b0; // [RL2]
      ls_nxt.ctl = 2'h0;
      ls_nxt.island = 1'b0;
      ls_nxt.data = 32'h0000_0000; // [RL1]
    end else begin
      ls_nxt.oe = 1'b1;
      // Sync sent in its chosen sense; inverted syncs idle asserted
      ls_nxt.ctl = {ls_r.act.pol[1] ? vs_i : ~vs_i,
                    ls_r.act.pol[0] ? hs_i : ~hs_i}; // [RL16] [RL17]
      if (de_i) begin
        ls_nxt.island = 1'b0;
        ls_nxt.data = pix_lanes;
      end else if (ls_r.act.hdmi) begin
        ls_nxt.island = 1'b1;
        if (aud_go) begin
          ls_nxt.data = audio_data_i; // [RL14]
        end else begin
          ls_nxt.data = 32'h0000_0000; // [RL12]
        end
      end else begin
        ls_nxt.island = 1'b0; // [RL13]
        ls_nxt.data = 32'h0000_0000;
      end
      if (ls_r.act.rev) begin
        ls_nxt.data = rev_lanes(ls_nxt.data); // [RL7]
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (!lrst_s2_r) begin
      ls_r <= '0;
      ls_r.pend <= to_cfg(`DPC_RESET);
      ls_r.act <= to_cfg(`DPC_RESET);
    end else begin
      ls_r <= ls_nxt;
    end
  end

  assign pipe_sel_o = ls_r.act.pipe;
  assign lane_data_o = ls_r.data;
  assign lane_ctl_o = ls_r.ctl;
  assign lane_island_o = ls_r.island;
  assign lane_oe_o = ls_r.oe;
  assign audio_take_o = ls_r.take;

endmodule

// ===== tb/tmds_port_checker.sv
`timescale 1ns/1ps
module tmds_port_checker (
  // Register side
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic reg_wr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic hot_plug_o,
  // Link side
  input wire logic link_clk_i,
  input wire logic vblank_i,
  input wire logic de_i,
  input wire logic audio_valid_i,
  input wire logic [31:0] audio_data_i,
  input wire logic audio_take_o,
  input wire logic [1:0] pipe_sel_o,
  input wire logic [31:0] lane_data_o,
  input wire logic [1:0] lane_ctl_o,
  input wire logic lane_island_o,
  input wire logic lane_oe_o
);
  localparam logic [31:0] WMASK = 32'hFC00_8E58;
  // ==========
  // Link domain
  a_off_quiet: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    !lane_oe_o |-> lane_data_o == 32'h0000_0000 && lane_ctl_o == 2'h0 && !lane_island_o)
    else $error("port off but lanes active");
  a_take_audio: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    audio_take_o |-> lane_island_o && (lane_data_o == $past(audio_data_i) ||
      lane_data_o == {$past(audio_data_i[7:0]), $past(audio_data_i[15:8]),
                      $past(audio_data_i[23:16]), $past(audio_data_i[31:24])}))
    else $error("audio sample not merged");
  a_take_cause: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    audio_take_o |-> lane_oe_o && $past(audio_valid_i) && !$past(de_i))
    else $error("audio taken without cause");
  a_null_zero: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    lane_island_o && !audio_take_o |-> lane_data_o == 32'h0000_0000)
    else $error("null packet not zero");
  a_oe_blank: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    $changed(lane_oe_o) |-> $past(vblank_i, 2) && !$past(vblank_i, 3))
    else $error("enable changed off blank");
  a_pipe_blank: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    $changed(pipe_sel_o) |-> $past(vblank_i) && !$past(vblank_i, 2))
    else $error("pipe changed off blank");
  // ==========
  // Register domain; covers for both domains
  a_wr_readback: assert property (@(posedge clk_i) disable iff (!rstn_i)
    reg_wr_i ##1 !reg_wr_i |=> (reg_rdata_o & WMASK) == ($past(reg_wdata_i, 2) & WMASK))
    else $error("readback differs from write");
  a_hot_plug: assert property (@(posedge clk_i) disable iff (!rstn_i)
    hot_plug_o |-> reg_rdata_o[11:10] == 2'h2 || $past(reg_rdata_o[11:10]) == 2'h2)
    else $error("hot plug outside tmds mode");
  c_audio: cover property (@(posedge link_clk_i) audio_take_o);
  c_oe: cover property (@(posedge link_clk_i) $rose(lane_oe_o));
  c_hot: cover property (@(posedge clk_i) hot_plug_o);
endmodule

bind tmds_port_control tmds_port_checker u_chk (.clk_i, .rstn_i, .reg_wr_i, .reg_wdata_i,
  .reg_rdata_o, .hot_plug_o, .link_clk_i, .vblank_i, .de_i, .audio_valid_i, .audio_data_i,
  .audio_take_o, .pipe_sel_o, .lane_data_o, .lane_ctl_o, .lane_island_o, .lane_oe_o);

// ===== tb/tmds_sink.sv
`timescale 1ns/1ps
module tmds_sink (
  // Pins toward the source
  output logic hot_plug_o,
  output logic serial_data_o
);
  // Plugged sink, serial data line pulled up at boot
  assign hot_plug_o = 1'h1;
  assign serial_data_o = 1'h1;
endmodule

// ===== tb/tb_tmds_port_control.sv
`timescale 1ns/1ps
module tb_tmds_port_control;
  logic clk_i = 0, link_clk_i = 0, rstn_i = 0, reg_wr_i = 0;
  logic vblank_i = 0, de_i = 0, hs_i = 0, vs_i = 0, audio_valid_i = 0;
  logic [31:0] reg_wdata_i = 32'h0000_0000, audio_data_i = 32'hA5A5_0F0F;
  logic [35:0] pix_i = 36'h1_2345_6789;
  logic [31:0] reg_rdata_o, lane_data_o;
  logic hot_plug_o, audio_present_o, audio_take_o, lane_island_o, lane_oe_o, hot_plug_detect_pin, dsb;
  logic [1:0] pipe_sel_o, lane_ctl_o;
  int err_count = 0, checks_done = 0;
  always #20 clk_i = ~clk_i;
  always #24 link_clk_i = ~link_clk_i;
  tmds_sink u_sink (.hot_plug_o(hot_plug_detect_pin), .serial_data_o(dsb));
  tmds_port_control DUT (.clk_i, .rstn_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
    .hot_plug_detect_pin_i(hot_plug_detect_pin), .display_serial_bus_data_i(dsb), .hot_plug_o,
    .audio_present_o, .link_clk_i, .vblank_i, .de_i, .hs_i, .vs_i, .pix_i, .audio_valid_i,
    .audio_data_i, .audio_take_o, .pipe_sel_o, .lane_data_o, .lane_ctl_o, .lane_island_o,
    .lane_oe_o);
  // ==========
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] d);
    @(negedge clk_i);
    reg_wr_i = 1;
    reg_wdata_i = d;
    @(negedge clk_i);
    reg_wr_i = 0;
    repeat (2) @(negedge clk_i);
    chk(reg_rdata_o, d & 32'hFC00_8E58 | 32'h0000_0004);
  endtask
  task automatic vb();
    repeat (12) @(negedge link_clk_i);
    vblank_i = 1;
    @(negedge link_clk_i);
    vblank_i = 0;
  endtask
  task automatic st(input logic d, input logic h, input logic v, input logic a);
    @(negedge link_clk_i);
    de_i = d;
    hs_i = h;
    vs_i = v;
    audio_valid_i = a;
    @(negedge link_clk_i);
  endtask
  // ==========
  // Scenarios
  task automatic t_reset();
    chk(reg_rdata_o, 32'h0000_0018);
    chk(lane_oe_o, 1'h0);
    repeat (8) @(negedge clk_i);
    chk(reg_rdata_o, 32'h0000_001C);
  endtask
  task automatic t_hdmi();
    wr(32'hC000_0A58);
    chk(lane_oe_o, 1'h0);
    chk(hot_plug_o, 1'h1);
    chk(audio_present_o, 1'h1);
    vb();
    st(1'h1, 1'h0, 1'h0, 1'h0);
    chk(lane_oe_o, 1'h1);
    chk(pipe_sel_o, 2'h2);
    chk(lane_data_o, 32'h0012_4578);
    st(1'h0, 1'h0, 1'h0, 1'h1);
    chk({lane_island_o, audio_take_o}, 2'h3);
    chk(lane_data_o, audio_data_i);
    st(1'h0, 1'h0, 1'h0, 1'h0);
    chk({lane_island_o, audio_take_o, lane_data_o[29:0]}, 32'h8000_0000);
  endtask
  task automatic t_pol();
    for (int p = 0; p < 4; p++) begin
      wr(32'hC000_0A40 | (p << 3));
      vb();
      st(1'h0, 1'h1, 1'h0, 1'h0);
      chk(lane_ctl_o, {~p[1], p[0]});
    end
  endtask
  task automatic t_dvi();
    wr(32'hC000_0840);
    vb();
    st(1'h0, 1'h0, 1'h0, 1'h1);
    chk({lane_island_o, audio_take_o, lane_data_o[29:0]}, 32'h0000_0000);
    wr(32'hC000_0640);
    chk(hot_plug_o, 1'h0);
    vb();
    st(1'h0, 1'h0, 1'h0, 1'h0);
    chk(lane_oe_o, 1'h0);
  endtask
  task automatic t_rev();
    wr(32'h8C00_0A18);
    chk(audio_present_o, 1'h0);
    vb();
    st(1'h1, 1'h0, 1'h0, 1'h0);
    chk(lane_data_o, 32'h9612_4578);
    wr(32'h8C00_8A18);
    vb();
    st(1'h1, 1'h0, 1'h0, 1'h0);
    chk(lane_data_o, 32'h9612_4578);
    wr(32'h0C00_8A18);
    vb();
    st(1'h1, 1'h0, 1'h0, 1'h0);
    chk({lane_oe_o, lane_data_o[30:0]}, 32'h0000_0000);
    wr(32'h8C00_8A18);
    vb();
    st(1'h1, 1'h0, 1'h0, 1'h0);
    chk(lane_data_o, 32'h7845_1296);
  endtask
  task automatic complete_run();
    $display("err_count=%0d checks_done=%0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk_i);
    rstn_i = 1;
    t_reset();
    t_hdmi();
    t_pol();
    t_dvi();
    t_rev();
    complete_run();
  end
  initial begin
    #2000000;
    err_count++;
    complete_run();
  end
endmodule
